// ==== cfg_seq_pkg.sv ====
// Package with the constants, types and figures of the configuration sequencer.
package cfg_seq_pkg;
   localparam int unsigned data_width      = 32;
   localparam int unsigned fifo_depth      = 16;
   localparam int unsigned count_width     = 16;
   localparam logic [15:0] init_done_delay = 16'h0008;
   localparam logic [15:0] reinit_cycles   = 16'h0004;

   typedef enum logic [0:0] {
      link_init_mode,
      link_update_mode
   } boot_mode_type;

   typedef enum {
      load_memory,
      link_training,
      core_load,
      initializing,
      user_mode,
      reinit_fabric
   } seq_state_type;
endpackage

// ==== image_stream_if.sv ====
// Interface that carries image words between the sequencer and the image buffer.
`timescale 1ns/1ps
`default_nettype none
interface image_stream_if;
   logic [cfg_seq_pkg::data_width-1:0] data;
   logic                               valid;
   logic                               ready;
   logic                               last;

   modport source (output data, output valid, output last, input ready);
   modport sink   (input data, input valid, input last, output ready);
endinterface
`default_nettype wire

// ==== image_fifo.sv ====
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module image_fifo #(
   parameter int unsigned width = 32,
   parameter int unsigned depth = 16
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             flush,
   image_stream_if.sink          in_port,
   image_stream_if.source        out_port
);
   localparam int unsigned aw = $clog2(depth);

   logic [width:0]  store_reg [depth];
   logic [aw-1:0]   wr_ptr_reg;
   logic [aw-1:0]   rd_ptr_reg;
   logic [aw:0]     count_reg;
   logic            push;
   logic            pop;

   // The last flag rides in the top bit of each stored word.
   // The count is one bit wider than the pointers, so full is compared at that width.
   assign in_port.ready  = (count_reg != (aw + 1)'(depth)) && !flush;
   assign out_port.valid = (count_reg != '0);
   assign out_port.data  = store_reg[rd_ptr_reg][width-1:0];
   assign out_port.last  = store_reg[rd_ptr_reg][width];
   assign push = in_port.valid && in_port.ready;
   assign pop  = out_port.valid && out_port.ready;

   always_ff @(posedge clock) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= {in_port.last, in_port.data};
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == aw'(depth - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == aw'(depth - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (aw + 1)'(push) - (aw + 1)'(pop);
      end
   end

   fifo_no_overflow_a: assert property (@(posedge clock) disable iff (!reset_n)
      count_reg <= (aw + 1)'(depth)) else $error("Image FIFO count above depth.");
endmodule
`default_nettype wire

// ==== fabric_writer.sv ====
// Writes buffered core image words into the configuration RAM cells.
`timescale 1ns/1ps
`default_nettype none
module fabric_writer (
   input  wire logic                             clock,
   input  wire logic                             reset_n,
   input  wire logic                             enable,
   image_stream_if.sink                          words,
   output logic                                  cell_write,
   output logic [cfg_seq_pkg::data_width-1:0]    cell_data,
   output logic                                  image_done
);
   // The writer drains every cycle while enabled, so the FIFO never holds more than one word.
   assign words.ready = enable;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cell_write <= 1'b0;
         cell_data  <= '0;
         image_done <= 1'b0;
      end else begin
         cell_write <= words.valid && enable;
         if (words.valid && enable) begin
            cell_data <= words.data;
         end
         image_done <= words.valid && enable && words.last;
      end
   end
endmodule
`default_nettype wire

// ==== cfg_sequencer.sv ====
// Configuration sequencer: periphery load, link training gate and core image loads.
//
// Contract
// - Init mode loads periphery from memory.
// - Init mode core image arrives over link.
// - Periphery flag high, then link training starts.
// - Training done puts link in L0.
// - Core image loaded raises core complete.
// - Full configuration enters user mode, init done.
// - Update mode loads whole image from memory.
// - Update mode raises periphery flag after load.
// - User mode serves traffic, accepts update trigger.
// - Update start pulls core complete low.
// - Update reinitialises fabric, then reprograms it.
// - Restart and status pins stay high during update.
// - Update end raises core complete, user mode.
// - One design uses one mode only.
// - Only reconfigurable core region is rewritten live.
// - Reconfigurable region holds only fabric cells.
// - Periphery image unchanged across core updates.
// - Core complete low during any core load.
`timescale 1ns/1ps
`default_nettype none
module cfg_sequencer (
   input  wire logic                             clock,
   input  wire logic                             reset_n,
   input  wire logic                             mode_update,
   input  wire logic                             init_done_enable,
   input  wire logic                             memory_load_done,
   output logic                                  memory_load_start,
   output logic                                  link_training_enable,
   input  wire logic                             link_training_done,
   output logic                                  link_in_l0,
   input  wire logic                             update_request,
   input  wire logic [cfg_seq_pkg::data_width-1:0] image_data,
   input  wire logic                             image_valid,
   input  wire logic                             image_last,
   output logic                                  image_ready,
   output logic                                  cell_write,
   output logic [cfg_seq_pkg::data_width-1:0]    cell_data,
   output logic                                  fabric_reinit,
   output logic                                  periphery_config_complete,
   output logic                                  core_config_complete,
   output logic                                  init_done,
   output logic                                  user_mode_active,
   output logic                                  config_restart_n_out,
   output logic                                  config_restart_n_oe,
   output logic                                  config_status_n_out,
   output logic                                  config_status_n_oe
);
   cfg_seq_pkg::seq_state_type  state_reg;
   cfg_seq_pkg::boot_mode_type  mode_reg;
   logic [1:0]                  load_done_sync_reg;
   logic [1:0]                  train_done_sync_reg;
   logic [1:0]                  update_sync_reg;
   logic                        update_seen_reg;
   logic [15:0]                 count_reg;
   logic                        image_done;
   logic                        load_done;
   logic                        train_done;
   logic                        update_edge;
   logic                        init_done_enable_q;
   logic                        user_mode_active_q;

   image_stream_if host_words ();
   image_stream_if cell_words ();

   // External status inputs cross in from other logic through two flip-flops.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         load_done_sync_reg  <= '0;
         train_done_sync_reg <= '0;
         update_sync_reg     <= '0;
      end else begin
         load_done_sync_reg  <= {load_done_sync_reg[0], memory_load_done};
         train_done_sync_reg <= {train_done_sync_reg[0], link_training_done};
         update_sync_reg     <= {update_sync_reg[0], update_request};
      end
   end
   assign load_done  = load_done_sync_reg[1];
   assign train_done = train_done_sync_reg[1];

   // The request is edge detected on the synchronised copy only.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         update_seen_reg <= 1'b0;
      end else begin
         update_seen_reg <= update_sync_reg[1];
      end
   end
   assign update_edge = update_sync_reg[1] && !update_seen_reg;

   // The mode strap is sampled every cycle in load_memory until the load is done, then held, so one design keeps one mode.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mode_reg <= cfg_seq_pkg::link_init_mode;
      end else if (state_reg == cfg_seq_pkg::load_memory && !load_done) begin
         mode_reg <= mode_update ? cfg_seq_pkg::link_update_mode
                                 : cfg_seq_pkg::link_init_mode;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_reg <= cfg_seq_pkg::load_memory;
      end else begin
         unique case (state_reg)
            cfg_seq_pkg::load_memory: begin
               if (load_done) begin
                  // Update mode brings the whole image, so link and core are live at once.
                  state_reg <= (mode_reg == cfg_seq_pkg::link_update_mode)
                     ? cfg_seq_pkg::initializing : cfg_seq_pkg::link_training;
               end
            end
            cfg_seq_pkg::link_training: begin
               if (train_done) begin
                  state_reg <= cfg_seq_pkg::core_load;
               end
            end
            cfg_seq_pkg::core_load: begin
               if (image_done) begin
                  state_reg <= cfg_seq_pkg::initializing;
               end
            end
            cfg_seq_pkg::initializing: begin
               if (count_reg == cfg_seq_pkg::init_done_delay) begin
                  state_reg <= cfg_seq_pkg::user_mode;
               end
            end
            cfg_seq_pkg::user_mode: begin
               if (update_edge) begin
                  state_reg <= cfg_seq_pkg::reinit_fabric;
               end
            end
            cfg_seq_pkg::reinit_fabric: begin
               if (count_reg == cfg_seq_pkg::reinit_cycles) begin
                  state_reg <= cfg_seq_pkg::core_load;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (state_reg == cfg_seq_pkg::initializing
                   || state_reg == cfg_seq_pkg::reinit_fabric) begin
         count_reg <= count_reg + 16'h0001;
      end else begin
         count_reg <= '0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         memory_load_start         <= 1'b0;
         periphery_config_complete <= 1'b0;
         link_training_enable      <= 1'b0;
         link_in_l0                <= 1'b0;
      end else begin
         memory_load_start <= (state_reg == cfg_seq_pkg::load_memory) && !load_done;
         // The flag never drops again, since core updates leave the periphery alone.
         if (state_reg == cfg_seq_pkg::load_memory && load_done) begin
            periphery_config_complete <= 1'b1;
         end
         // Training only starts once the periphery flag is visible.
         link_training_enable <= periphery_config_complete;
         if (periphery_config_complete && (train_done
             || mode_reg == cfg_seq_pkg::link_update_mode)) begin
            link_in_l0 <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         core_config_complete <= 1'b0;
         init_done            <= 1'b0;
         user_mode_active     <= 1'b0;
         fabric_reinit        <= 1'b0;
      end else begin
         if (state_reg == cfg_seq_pkg::reinit_fabric
             || state_reg == cfg_seq_pkg::core_load) begin
            core_config_complete <= 1'b0;
         end else if (state_reg == cfg_seq_pkg::initializing
                      || state_reg == cfg_seq_pkg::user_mode) begin
            core_config_complete <= 1'b1;
         end
         init_done        <= init_done_enable && state_reg == cfg_seq_pkg::user_mode;
         user_mode_active <= state_reg == cfg_seq_pkg::user_mode;
         fabric_reinit    <= state_reg == cfg_seq_pkg::reinit_fabric;
      end
   end

   // Restart and status pins are released high; low enable would mean driving them.
   assign config_restart_n_out = 1'b1;
   assign config_restart_n_oe  = 1'b1;
   assign config_status_n_out  = 1'b1;
   assign config_status_n_oe   = 1'b1;

   // Only core words enter the fabric path; periphery never passes through here.
   assign host_words.data  = image_data;
   assign host_words.valid = image_valid && state_reg == cfg_seq_pkg::core_load;
   assign host_words.last  = image_last;
   assign image_ready      = host_words.ready && state_reg == cfg_seq_pkg::core_load;

   image_fifo #(
      .width (cfg_seq_pkg::data_width),
      .depth (cfg_seq_pkg::fifo_depth)
   ) fifo_inst (
      .clock    (clock),
      .reset_n  (reset_n),
      .flush    (state_reg == cfg_seq_pkg::reinit_fabric),
      .in_port  (host_words),
      .out_port (cell_words)
   );

   fabric_writer writer_inst (
      .clock      (clock),
      .reset_n    (reset_n),
      .enable     (state_reg == cfg_seq_pkg::core_load),
      .words      (cell_words),
      .cell_write (cell_write),
      .cell_data  (cell_data),
      .image_done (image_done)
   );

   training_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      link_training_enable |-> $past(periphery_config_complete))
      else $error("Training enabled before periphery flag.");
   core_low_load_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == cfg_seq_pkg::core_load) |=> !core_config_complete)
      else $error("Core complete high during core load.");
   update_drops_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == cfg_seq_pkg::user_mode && update_edge) |=> ##1 !core_config_complete)
      else $error("Core complete not dropped at update.");
   pins_high_a: assert property (@(posedge clock) disable iff (!reset_n)
      config_restart_n_out && config_status_n_out)
      else $error("Restart or status pin low.");
   image_done_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == cfg_seq_pkg::core_load && image_done) |=> ##1 core_config_complete)
      else $error("Core complete not raised after image.");
   periph_sticky_a: assert property (@(posedge clock) disable iff (!reset_n)
      $past(periphery_config_complete) |-> periphery_config_complete)
      else $error("Periphery flag dropped.");
   init_done_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      init_done |-> init_done_enable_q && user_mode_active_q)
      else $error("Init done without enable or user mode.");
   reinit_length_a: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(fabric_reinit) |-> fabric_reinit [*5] ##1 !fabric_reinit)
      else $error("Fabric reinit length wrong.");
   update_l0_a: assert property (@(posedge clock) disable iff (!reset_n)
      (mode_reg == cfg_seq_pkg::link_update_mode && user_mode_active) |-> link_in_l0)
      else $error("Update mode user state without link.");

   always_ff @(posedge clock) begin
      init_done_enable_q <= init_done_enable;
      user_mode_active_q <= state_reg == cfg_seq_pkg::user_mode;
   end

   boot_init_c: cover property (@(posedge clock) disable iff (!reset_n)
      mode_reg == cfg_seq_pkg::link_init_mode && $rose(user_mode_active));
   boot_update_c: cover property (@(posedge clock) disable iff (!reset_n)
      mode_reg == cfg_seq_pkg::link_update_mode && $rose(user_mode_active));
   core_update_c: cover property (@(posedge clock) disable iff (!reset_n)
      $fell(fabric_reinit));
   fifo_full_c: cover property (@(posedge clock) disable iff (!reset_n)
      image_valid && !image_ready && state_reg == cfg_seq_pkg::core_load);
endmodule
`default_nettype wire

// ==== host_memory_model.sv ====
// Model of the link host and the configuration memory facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module host_memory_model #(
   parameter int                                 load_delay  = 6,
   parameter int                                 train_delay = 3,
   parameter logic [31:0]                        word_base   = 32'hc0de_0000
) (
   input  wire logic                             clock,
   input  wire logic                             reset_n,
   input  wire logic                             memory_load_start,
   input  wire logic                             link_training_enable,
   input  wire logic                             link_in_l0,
   input  wire logic                             periphery_config_complete,
   input  wire logic                             image_ready,
   input  wire logic                             image_go,
   input  wire logic                             stall,
   input  wire logic [7:0]                       image_words,
   output logic                                  memory_load_done,
   output logic                                  link_training_done,
   output logic                                  image_valid,
   output logic                                  image_last,
   output logic                                  image_busy,
   output logic [cfg_seq_pkg::data_width-1:0]    image_data
);
   int                                           load_count;
   int                                           train_count;
   logic [7:0]                                   sent;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         load_count       <= 0;
         memory_load_done <= 1'b0;
      end else if (load_count == load_delay) begin
         memory_load_done <= 1'b1;
      end else if (memory_load_start) begin
         load_count <= load_count + 1;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         train_count        <= 0;
         link_training_done <= 1'b0;
      end else if (train_count == train_delay) begin
         link_training_done <= 1'b1;
      end else if (link_training_enable) begin
         train_count <= train_count + 1;
      end
   end

   // Data toggles on each busy cycle that sends no word while no word is waiting, and after the last word, so a stale word can never pass for a fresh one.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         image_busy  <= 1'b0;
         image_valid <= 1'b0;
         image_last  <= 1'b0;
         image_data  <= '1;
         sent        <= 8'h00;
      end else if (image_go) begin
         image_busy <= 1'b1;
         sent       <= 8'h00;
      end else if (image_valid && image_ready && image_last) begin
         image_valid <= 1'b0;
         image_last  <= 1'b0;
         image_busy  <= 1'b0;
         image_data  <= ~image_data;
      end else if (image_busy && (!image_valid || image_ready)) begin
         if (!stall && link_in_l0 && periphery_config_complete) begin
            image_valid <= 1'b1;
            image_last  <= (sent == image_words - 8'h01);
            image_data  <= word_base + 32'(sent);
            sent        <= sent + 8'h01;
         end else begin
            image_valid <= 1'b0;
            image_data  <= ~image_data;
         end
      end
   end
endmodule
`default_nettype wire

// ==== pcie_core_image_config_sequencer_bench.sv ====
// Self-checking bench for the configuration sequencer and its far-side model.
`timescale 1ns/1ps
`default_nettype none
module pcie_core_image_config_sequencer_bench;
   localparam logic [31:0]                       word_base = 32'hc0de_0000;
   logic                                         clock = 1'b0;
   logic                                         reset_n = 1'b0;
   logic                                         mode_update = 1'b0;
   logic                                         init_done_enable = 1'b0;
   logic                                         update_request = 1'b0;
   logic                                         image_go = 1'b0;
   logic                                         stall = 1'b0;
   logic [7:0]                                   image_words = 8'h01;
   logic                                         memory_load_done, memory_load_start;
   logic                                         link_training_enable, link_training_done;
   logic                                         link_in_l0, image_valid, image_last;
   logic                                         image_ready, image_busy, cell_write;
   logic [cfg_seq_pkg::data_width-1:0]           image_data, cell_data;
   logic                                         fabric_reinit, periphery_config_complete;
   logic                                         core_config_complete, init_done;
   logic                                         user_mode_active;
   logic                                         config_restart_n_out, config_restart_n_oe;
   logic                                         config_status_n_out, config_status_n_oe;
   int                                           mismatches = 0;
   int                                           tests_run = 0;
   int                                           write_index = 0;
   // Both pins have pull-ups, so a released pin reads high.
   wire logic restart_level = config_restart_n_oe ? 1'b1 : config_restart_n_out;
   wire logic status_level  = config_status_n_oe ? 1'b1 : config_status_n_out;

   always #20 clock = ~clock;

   cfg_sequencer uut (.clock(clock), .reset_n(reset_n), .mode_update(mode_update),
      .init_done_enable(init_done_enable), .memory_load_done(memory_load_done),
      .memory_load_start(memory_load_start), .link_training_enable(link_training_enable),
      .link_training_done(link_training_done), .link_in_l0(link_in_l0),
      .update_request(update_request), .image_data(image_data), .image_valid(image_valid),
      .image_last(image_last), .image_ready(image_ready), .cell_write(cell_write),
      .cell_data(cell_data), .fabric_reinit(fabric_reinit),
      .periphery_config_complete(periphery_config_complete),
      .core_config_complete(core_config_complete), .init_done(init_done),
      .user_mode_active(user_mode_active), .config_restart_n_out(config_restart_n_out),
      .config_restart_n_oe(config_restart_n_oe), .config_status_n_out(config_status_n_out),
      .config_status_n_oe(config_status_n_oe));

   host_memory_model #(.word_base(word_base)) far_side (.clock(clock), .reset_n(reset_n),
      .memory_load_start(memory_load_start), .link_training_enable(link_training_enable),
      .link_in_l0(link_in_l0), .periphery_config_complete(periphery_config_complete),
      .image_ready(image_ready), .image_go(image_go), .stall(stall),
      .image_words(image_words), .memory_load_done(memory_load_done),
      .link_training_done(link_training_done), .image_valid(image_valid),
      .image_last(image_last), .image_busy(image_busy), .image_data(image_data));

   task automatic check(input string what, input logic [31:0] expected, input logic [31:0] seen);
      tests_run++;
      if (seen !== expected) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, expected, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return periphery_config_complete;
         1: return link_in_l0;
         2: return core_config_complete;
         3: return user_mode_active;
         4: return image_ready;
         default: return image_busy;
      endcase
   endfunction

   task automatic wait_until(input int k, input logic level, input string what);
      int n;
      n = 0;
      while (pick(k) !== level && n < 400) begin
         step(1);
         n++;
      end
      check(what, 32'(level), 32'(pick(k)));
   endtask

   task automatic do_reset(input logic mode);
      reset_n = 1'b0;
      mode_update = mode;
      step(8);
      reset_n = 1'b1;
   endtask

   task automatic send_image(input logic [7:0] n, input logic slow);
      write_index = 0;
      image_words = n;
      image_go = 1'b1;
      stall = slow;
      step(1);
      image_go = 1'b0;
      step(6);
      stall = 1'b0;
      wait_until(5, 1'b0, "image sent");
      step(6);
      check("words written", 32'(n), 32'(write_index));
   endtask

   always @(negedge clock) begin
      if (reset_n === 1'b1) begin
         check("restart level", 32'h0000_0001, 32'(restart_level));
         check("status level", 32'h0000_0001, 32'(status_level));
         if (image_ready === 1'b1) begin
            check("core complete in load", 32'h0000_0000, 32'(core_config_complete));
         end
         if (cell_write === 1'b1) begin
            check("cell data", word_base + 32'(write_index), cell_data);
            check("reinit before write", 32'h0000_0000, 32'(fabric_reinit));
            write_index++;
         end
      end
   end

   task automatic test_init_boot;
      init_done_enable = 1'b1;
      do_reset(1'b0);
      update_request = 1'b1;
      step(4);
      update_request = 1'b0;
      check("ready before link", 32'h0000_0000, 32'(image_ready));
      wait_until(0, 1'b1, "periphery flag");
      check("training held", 32'h0000_0000, 32'(link_training_enable));
      check("load start off", 32'h0000_0000, 32'(memory_load_start));
      step(1);
      check("training started", 32'h0000_0001, 32'(link_training_enable));
      wait_until(1, 1'b1, "link in l0");
      check("core complete low", 32'h0000_0000, 32'(core_config_complete));
      send_image(8'h14, 1'b0);
      wait_until(2, 1'b1, "core complete");
      wait_until(3, 1'b1, "user mode");
      step(1);
      check("init done", 32'h0000_0001, 32'(init_done));
      step(10);
      check("early trigger ignored", 32'h0000_0001, 32'(core_config_complete));
   endtask

   // The trigger is held for several cycles because it crosses a two-stage synchroniser.
   task automatic test_update;
      update_request = 1'b1;
      step(4);
      update_request = 1'b0;
      wait_until(2, 1'b0, "update core complete low");
      check("fabric reinit", 32'h0000_0001, 32'(fabric_reinit));
      check("periphery kept", 32'h0000_0001, 32'(periphery_config_complete));
      wait_until(4, 1'b1, "ready for image");
      send_image(8'h05, 1'b1);
      wait_until(2, 1'b1, "core complete back");
      wait_until(3, 1'b1, "user mode back");
      check("link stays up", 32'h0000_0001, 32'(link_in_l0));
   endtask

   task automatic test_update_boot;
      init_done_enable = 1'b0;
      do_reset(1'b1);
      wait_until(0, 1'b1, "full image flag");
      wait_until(3, 1'b1, "update user mode");
      check("link up", 32'h0000_0001, 32'(link_in_l0));
      check("core complete", 32'h0000_0001, 32'(core_config_complete));
      check("init done off", 32'h0000_0000, 32'(init_done));
      init_done_enable = 1'b1;
      step(2);
      check("init done on", 32'h0000_0001, 32'(init_done));
      test_update();
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      test_init_boot();
      test_update();
      test_update_boot();
      report_and_stop();
   end

   initial begin
      repeat (6000) @(posedge clock);
      mismatches++;
      $display("[ERR] watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule
`default_nettype wire
